// >>> design/cmp_pkg.sv
// constants, field layouts and carrier types for the comparator and reference block
package cmp_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_LADDER = 8'h0C;
  // comparator_control field positions
  localparam int EN_BIT = 15;
  localparam int PINOE_BIT = 14;
  localparam int INV_BIT = 13;
  localparam int LP_BIT = 12;
  localparam int EVT_BIT = 9;
  localparam int RES_BIT = 8;
  localparam int EDGE_HI = 7;
  localparam int EDGE_LO = 6;
  localparam int NONINV_BIT = 4;
  localparam int INVSEL_HI = 1;
  localparam int INVSEL_LO = 0;
  // comparator_module_status field positions
  localparam int IDLE_BIT = 15;
  localparam int EVT2_BIT = 9;
  localparam int EVT1_BIT = 8;
  localparam int RES2_BIT = 1;
  localparam int RES1_BIT = 0;
  // reference_ladder_control field positions
  localparam int LEN_BIT = 7;
  localparam int LOE_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int SRC_BIT = 4;
  // writable masks and reset values
  localparam logic [15:0] CTRL_WMASK = 16'hF0D3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] LADDER_WMASK = 16'h00FF;
  localparam logic [15:0] LADDER_RESET = 16'h0000;
  // edge select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // inverting-input select encodings
  localparam logic [1:0] INVSEL_PIN = 2'h0;
  localparam logic [1:0] INVSEL_BG = 2'h3;
  localparam int NUM_CMP = 2;

  // per-comparator analog control bundle
  typedef struct packed {
    logic enable;
    logic lowPower;
    logic noninvRef;
    logic [1:0] invSel;
  } cmp_analog_s;

  // ladder analog control bundle
  typedef struct packed {
    logic enable;
    logic pinOut;
    logic range;
    logic source;
    logic [3:0] level;
  } ladder_analog_s;

  // ahb-lite slave request
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ahb_req_s;
endpackage

// >>> design/comparator_event_and_vref_control.sv
// control registers, event logic and ahb-lite slave for two comparators and the reference ladder
//
// Overview of operation
// - each comparator runs only while its enable bit is set
// - pin-output enable drives the raw result onto that comparator's output pin
// - invert bit clear: result 1 when positive input higher; set: inverted
// - low-power select bit puts the comparator into low-power mode
// - selected event sets the sticky event flag, which blocks further triggers
// - edge select 11 raises an event on any result change while flag clear
// - edge select 10: falling edge, or rising edge when inverted
// - edge select 01: rising edge, or falling edge when inverted
// - edge select 00 raises no trigger, event or interrupt
// - noninverting select picks internal reference when set, positive pin when clear
// - inverting select 11 picks half bandgap, 00 picks the negative pin
// - idle-stop bit suppresses interrupts in idle while comparators stay enabled
// - status shows event flags: comparator 2 at bit 9, comparator 1 at bit 8
// - status shows results: comparator 2 at bit 1, comparator 1 at bit 0
// - ladder enable powers the reference circuit
// - ladder pin-output bit connects the reference to its pin
// - range select: 1/24 steps from zero, or 1/32 steps from one quarter
// - source select picks external reference pins or analog supply rails
// - level code 0..15 taps the ladder; external source adds negative reference
// - output pin carries the raw unsynchronised comparator result
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module comparator_event_and_vref_control (
  input wire logic clock,
  input wire logic rst_n,
  input wire cmp_pkg::ahb_req_s ahbReq,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] rawCompare,
  input wire logic idleMode,
  output logic [1:0] cmpPinDrive,
  output cmp_pkg::cmp_analog_s [1:0] cmpAnalog,
  output cmp_pkg::ladder_analog_s ladderAnalog,
  output logic [1:0] cmpTrigger,
  output logic [1:0] cmpIrq
);
  import cmp_pkg::*;

  logic [15:0] ctrl_r [NUM_CMP];
  logic [15:0] ladder_r;
  logic idleSuppress_r;
  logic [1:0] event_r;
  logic [1:0] adjPrev_r;
  logic [1:0] adjNow;
  logic [1:0] hit;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic rdValid;

  // address decode shared by read and write paths
  function automatic logic [2:0] decode(input logic [7:0] a);
    case (a)
      OFF_CTRL1: decode = 3'h1;
      OFF_CTRL2: decode = 3'h2;
      OFF_STAT: decode = 3'h3;
      OFF_LADDER: decode = 3'h4;
      default: decode = 3'h0;
    endcase
  endfunction

  // readback word for an offset; unmapped reads as zero
  function automatic logic [15:0] readWord(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case (decode(a))
      // the live flag and result show through here as well as in the status word
      3'h1: begin
        w = ctrl_r[0];
        w[EVT_BIT] = event_r[0];
        w[RES_BIT] = adjNow[0];
      end
      3'h2: begin
        w = ctrl_r[1];
        w[EVT_BIT] = event_r[1];
        w[RES_BIT] = adjNow[1];
      end
      3'h3: begin
        w[IDLE_BIT] = idleSuppress_r;
        w[EVT2_BIT] = event_r[1];
        w[EVT1_BIT] = event_r[0];
        w[RES2_BIT] = adjNow[1];
        w[RES1_BIT] = adjNow[0];
      end
      3'h4: w = ladder_r;
      default: w = 16'h0000;
    endcase
    readWord = w;
  endfunction

  assign rdValid = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1] & ~ahbReq.hwrite;

  // bus slave always answers in zero wait states with okay
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // write address phase capture; data lands in the following cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1] & ahbReq.hwrite;
      wrAddr_r <= ahbReq.haddr[7:0];
    end
  end

  // read data registered at the address phase so hrdata comes from a flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdValid) begin
      hrdata <= {16'h0000, readWord(ahbReq.haddr[7:0])};
    end
  end

  // comparator control registers; result and event bits live elsewhere
  generate
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_ctrl
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          ctrl_r[i] <= CTRL_RESET;
        end else if (wrPend_r && decode(wrAddr_r) == 3'(i + 1)) begin
          ctrl_r[i] <= hwdata[15:0] & CTRL_WMASK & ~(16'h0001 << EVT_BIT);
        end
      end
    end
  endgenerate

  // status idle bit and ladder register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idleSuppress_r <= STAT_RESET[IDLE_BIT];
      ladder_r <= LADDER_RESET;
    end else if (wrPend_r) begin
      if (decode(wrAddr_r) == 3'h3) begin
        idleSuppress_r <= hwdata[IDLE_BIT];
      end
      if (decode(wrAddr_r) == 3'h4) begin
        ladder_r <= hwdata[15:0] & LADDER_WMASK;
      end
    end
  end

  // polarity adjust and edge match per comparator
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      adjNow[i] = (rawCompare[i] ^ ctrl_r[i][INV_BIT]) & ctrl_r[i][EN_BIT];
      hit[i] = 1'b0;
      if (ctrl_r[i][EN_BIT] && !event_r[i]) begin
        case (ctrl_r[i][EDGE_HI:EDGE_LO])
          EDGE_ANY: hit[i] = adjNow[i] ^ adjPrev_r[i];
          // fall when plain, rise when inverted: edge on raw result falling
          EDGE_FALL: hit[i] = ctrl_r[i][INV_BIT] ? (adjNow[i] & ~adjPrev_r[i])
                                                 : (~adjNow[i] & adjPrev_r[i]);
          EDGE_RISE: hit[i] = ctrl_r[i][INV_BIT] ? (~adjNow[i] & adjPrev_r[i])
                                                 : (adjNow[i] & ~adjPrev_r[i]);
          EDGE_NONE: hit[i] = 1'b0;
          default: hit[i] = 1'b0;
        endcase
      end
    end
  end

  // previous-cycle result for edge detection
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adjPrev_r <= 2'b00;
    end else begin
      adjPrev_r <= adjNow;
    end
  end

  // sticky event flags; a new hit wins over a software clear in the same cycle
  generate
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_evt
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          event_r[i] <= 1'b0;
        end else if (hit[i]) begin
          event_r[i] <= 1'b1;
        end else if (wrPend_r && decode(wrAddr_r) == 3'(i + 1)) begin
          event_r[i] <= hwdata[EVT_BIT];
        end
      end
    end
  endgenerate

  // trigger and interrupt pulses; idle suppression only blocks the interrupt
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmpTrigger <= 2'b00;
      cmpIrq <= 2'b00;
    end else begin
      cmpTrigger <= hit;
      cmpIrq <= hit & {2{~(idleSuppress_r & idleMode)}};
    end
  end

  // analog controls, registered so every output is a flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmpAnalog <= '0;
      ladderAnalog <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cmpAnalog[i].enable <= ctrl_r[i][EN_BIT];
        cmpAnalog[i].lowPower <= ctrl_r[i][LP_BIT];
        cmpAnalog[i].noninvRef <= ctrl_r[i][NONINV_BIT];
        cmpAnalog[i].invSel <= ctrl_r[i][INVSEL_HI:INVSEL_LO];
      end
      ladderAnalog.enable <= ladder_r[LEN_BIT];
      ladderAnalog.pinOut <= ladder_r[LOE_BIT];
      ladderAnalog.range <= ladder_r[RANGE_BIT];
      ladderAnalog.source <= ladder_r[SRC_BIT];
      ladderAnalog.level <= ladder_r[3:0];
    end
  end

  // pin gate: the analog pad passes the raw result while this enable is high;
  // the digital side only supplies the enable, so the pin path stays unsynchronised
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmpPinDrive <= 2'b00;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cmpPinDrive[i] <= ctrl_r[i][PINOE_BIT] & ctrl_r[i][EN_BIT];
      end
    end
  end

  // assertions
  property p_evt_sticky;
    @(posedge clock) disable iff (!rst_n)
      event_r[0] && !(wrPend_r && decode(wrAddr_r) == 3'h1) |=> event_r[0];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event flag dropped");

  property p_block_while_set;
    @(posedge clock) disable iff (!rst_n) event_r[1] |=> cmpTrigger[1] == 1'b0;
  endproperty
  a_block_while_set: assert property (p_block_while_set) else $error("trig with flag");

  property p_any_change;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[0][EN_BIT] && ctrl_r[0][EDGE_HI:EDGE_LO] == EDGE_ANY && !event_r[0]
      && $changed(adjNow[0]) && adjPrev_r[0] != adjNow[0] |=> event_r[0] && cmpTrigger[0];
  endproperty
  a_any_change: assert property (p_any_change) else $error("missed change event");

  property p_fall_plain;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[0][EN_BIT] && ctrl_r[0][EDGE_HI:EDGE_LO] == EDGE_FALL && !ctrl_r[0][INV_BIT]
      && !event_r[0] && adjPrev_r[0] && !adjNow[0] |=> event_r[0];
  endproperty
  a_fall_plain: assert property (p_fall_plain) else $error("missed falling event");

  property p_rise_plain;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[1][EN_BIT] && ctrl_r[1][EDGE_HI:EDGE_LO] == EDGE_RISE && !ctrl_r[1][INV_BIT]
      && !event_r[1] && !adjPrev_r[1] && adjNow[1] |=> event_r[1] && cmpTrigger[1];
  endproperty
  a_rise_plain: assert property (p_rise_plain) else $error("missed rising event");

  property p_none;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[0][EDGE_HI:EDGE_LO] == EDGE_NONE |=> !cmpTrigger[0];
  endproperty
  a_none: assert property (p_none) else $error("event while disabled");

  property p_idle_quiet;
    @(posedge clock) disable iff (!rst_n) idleSuppress_r && idleMode |=> cmpIrq == 2'b00;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("irq in idle");

  property p_mirror;
    @(posedge clock) disable iff (!rst_n)
      rdValid && decode(ahbReq.haddr[7:0]) == 3'h3
      |=> hrdata[EVT2_BIT] == $past(event_r[1]) && hrdata[RES1_BIT] == $past(adjNow[0]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("status mirror wrong");

  property p_ladder_follow;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> ladderAnalog.level == $past(ladder_r[3:0])
      && ladderAnalog.enable == $past(ladder_r[LEN_BIT]);
  endproperty
  a_ladder_follow: assert property (p_ladder_follow) else $error("ladder control lag");

  property p_disabled_quiet;
    @(posedge clock) disable iff (!rst_n) !ctrl_r[1][EN_BIT] |=> !cmpTrigger[1];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("trigger while off");

  property p_off_reads_low;
    @(posedge clock) disable iff (!rst_n) !ctrl_r[0][EN_BIT] |-> !adjNow[0];
  endproperty
  a_off_reads_low: assert property (p_off_reads_low) else $error("off result not low");

  property p_invert;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[1][EN_BIT] |-> (ctrl_r[1][INV_BIT] ? adjNow[1] != rawCompare[1]
                                                : adjNow[1] == rawCompare[1]);
  endproperty
  a_invert: assert property (p_invert) else $error("result polarity wrong");

  property p_pin_on;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[0][PINOE_BIT] && ctrl_r[0][EN_BIT] |=> cmpPinDrive[0];
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not driven");

  property p_pin_off;
    @(posedge clock) disable iff (!rst_n) !ctrl_r[1][PINOE_BIT] |=> !cmpPinDrive[1];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

  property p_hit_sets;
    @(posedge clock) disable iff (!rst_n) hit[0] |=> event_r[0] && cmpTrigger[0];
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("hit did not set flag");

  property p_fall_inv;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[1][EN_BIT] && ctrl_r[1][EDGE_HI:EDGE_LO] == EDGE_FALL && ctrl_r[1][INV_BIT]
      && !event_r[1] && !adjPrev_r[1] && adjNow[1] |=> event_r[1] && cmpTrigger[1];
  endproperty
  a_fall_inv: assert property (p_fall_inv) else $error("missed inverted fall event");

  property p_rise_inv;
    @(posedge clock) disable iff (!rst_n)
      ctrl_r[0][EN_BIT] && ctrl_r[0][EDGE_HI:EDGE_LO] == EDGE_RISE && ctrl_r[0][INV_BIT]
      && !event_r[0] && adjPrev_r[0] && !adjNow[0] |=> event_r[0] && cmpTrigger[0];
  endproperty
  a_rise_inv: assert property (p_rise_inv) else $error("missed inverted rise event");

  property p_irq_follows;
    @(posedge clock) disable iff (!rst_n) !(idleSuppress_r && idleMode) |=> cmpIrq == cmpTrigger;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq lost outside idle");

  property p_mirror_other;
    @(posedge clock) disable iff (!rst_n)
      rdValid && decode(ahbReq.haddr[7:0]) == 3'h3
      |=> hrdata[RES2_BIT] == $past(adjNow[1]) && hrdata[EVT1_BIT] == $past(event_r[0]);
  endproperty
  a_mirror_other: assert property (p_mirror_other) else $error("status mirror lag");

  property p_analog_follow;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> cmpAnalog[1].lowPower == $past(ctrl_r[1][LP_BIT])
      && cmpAnalog[1].invSel == $past(ctrl_r[1][INVSEL_HI:INVSEL_LO]);
  endproperty
  a_analog_follow: assert property (p_analog_follow) else $error("core setup lag");

  property p_ladder_pins;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> ladderAnalog.range == $past(ladder_r[RANGE_BIT])
      && ladderAnalog.source == $past(ladder_r[SRC_BIT])
      && ladderAnalog.pinOut == $past(ladder_r[LOE_BIT]);
  endproperty
  a_ladder_pins: assert property (p_ladder_pins) else $error("ladder select lag");

  c_evt0: cover property (@(posedge clock) disable iff (!rst_n) $rose(event_r[0]));
  c_evt1_clear: cover property (@(posedge clock) disable iff (!rst_n) $fell(event_r[1]));
  c_idle_block: cover property (@(posedge clock) disable iff (!rst_n) cmpTrigger[0] && !cmpIrq[0]);
  c_irq1: cover property (@(posedge clock) disable iff (!rst_n) cmpIrq[1]);
  c_pin_on: cover property (@(posedge clock) disable iff (!rst_n) cmpPinDrive[0]);
endmodule // comparator_event_and_vref_control

// >>> tb/analog_cores_model.sv
// behavioural model of the two analog comparator cores and the reference ladder
`timescale 1ns/1ps
module analog_cores_model #(
  parameter int SPAN_MV = 3300,
  parameter int VREF_LO_MV = 200,
  parameter int HALF_BANDGAP_MV = 600
) (
  input wire logic clock,
  input wire cmp_pkg::cmp_analog_s [1:0] cmpAnalog,
  input wire cmp_pkg::ladder_analog_s ladderAnalog,
  input wire logic [1:0][11:0] posMv,
  input wire logic [1:0][11:0] negMv,
  output logic [1:0] rawCompare
);
  import cmp_pkg::*;
  int vrefMv;
  logic idleToggle = 1'b0;
  // a core that is off shows a changing level, so a stale result never looks valid
  always_ff @(posedge clock) begin
    idleToggle <= ~idleToggle;
  end
  // ladder tap; powered down gives zero
  always_comb begin
    vrefMv = 0;
    if (ladderAnalog.enable) begin
      vrefMv = ladderAnalog.range ? SPAN_MV * ladderAnalog.level / 24
          : SPAN_MV / 4 + SPAN_MV * ladderAnalog.level / 32;
      if (ladderAnalog.source) vrefMv += VREF_LO_MV;
    end
  end
  // input selection and comparison; low power only slows a real core, not modelled
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rawCompare[i] = idleToggle ^ i[0];
      if (cmpAnalog[i].enable)
        rawCompare[i] = (cmpAnalog[i].noninvRef ? vrefMv : int'(posMv[i])) >
            (cmpAnalog[i].invSel == INVSEL_BG ? HALF_BANDGAP_MV : int'(negMv[i]));
    end
  end
endmodule // analog_cores_model

// >>> tb/comparator_event_and_vref_control_test.sv
// self-checking bench for the comparator event and reference control block
`timescale 1ns/1ps
module comparator_event_and_vref_control_test;
  import cmp_pkg::*;
  logic clock, rst_n, hSel, hWrite, idleMode, hreadyout, hresp, pin, sup;
  logic [31:0] hAddr, hwdata, hrdata, rd, w;
  logic [1:0] hTrans, rawCompare, cmpPinDrive, cmpTrigger, cmpIrq;
  logic [2:0] hSize;
  logic [1:0][11:0] posMv, negMv;
  ahb_req_s ahbReq;
  cmp_analog_s [1:0] cmpAnalog;
  ladder_analog_s ladderAnalog;
  int nErrors, samplesChecked, seed, k;
  int trig[2], irq[2];
  assign ahbReq = {hSel, hAddr, hTrans, hWrite, hSize, hreadyout};
  comparator_event_and_vref_control u_dut (
    .clock(clock), .rst_n(rst_n), .ahbReq(ahbReq), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rawCompare(rawCompare), .idleMode(idleMode),
    .cmpPinDrive(cmpPinDrive), .cmpAnalog(cmpAnalog), .ladderAnalog(ladderAnalog),
    .cmpTrigger(cmpTrigger), .cmpIrq(cmpIrq));
  analog_cores_model u_cores (
    .clock(clock), .cmpAnalog(cmpAnalog), .ladderAnalog(ladderAnalog), .posMv(posMv),
    .negMv(negMv), .rawCompare(rawCompare));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // pulse counters see each edge's values before that edge's updates land
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      trig[i] += int'(cmpTrigger[i] === 1'b1);
      irq[i] += int'(cmpIrq[i] === 1'b1);
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reportAndStop();
    if (nErrors == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one single transfer; entered just after an edge, waits on hready at both phases
  // no cycle count is assumed: only the watchdog ends a wait that never ends
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hSel <= 1'b1;
    hAddr <= {24'h00_0000, a};
    hTrans <= 2'b10;
    hWrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hSel <= 1'b0;
    hTrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // whether a result change to newRaw counts as an event for this edge select
  function automatic int hits(input logic [1:0] sel, input logic inv, input logic newRaw);
    logic adjNew;
    adjNew = newRaw ^ inv;
    case (sel)
      EDGE_RISE: return int'(inv ? !adjNew : adjNew);
      EDGE_FALL: return int'(inv ? adjNew : !adjNew);
      EDGE_ANY: return 1;
      default: return 0;
    endcase
  endfunction
  // raw result up then down; a flag left set by the first change must block the second
  task automatic eventCase(input int c, input logic [1:0] sel, input logic inv);
    logic [7:0] off;
    logic [31:0] ctl;
    int t0, i0, e;
    off = c ? OFF_CTRL2 : OFF_CTRL1;
    pin = 1'($random(seed));
    sup = 1'($random(seed));
    idleMode <= 1'($random(seed));
    posMv[c] <= 12'd500;
    bus(1'b1, OFF_STAT, {16'h0000, sup, 15'h0000});
    ctl = {16'h0000, 1'b1, pin, inv, 5'h00, sel, 6'h00};
    bus(1'b1, off, ctl);
    repeat (3) @(posedge clock);
    bus(1'b1, off, ctl);
    repeat (2) @(posedge clock);
    chk("pin drive", 32'(pin), 32'(cmpPinDrive[c]));
    t0 = trig[c];
    i0 = irq[c];
    posMv[c] <= 12'd1500;
    repeat (4) @(posedge clock);
    posMv[c] <= 12'd500;
    repeat (4) @(posedge clock);
    e = hits(sel, inv, 1'b1);
    if (e == 0) e = hits(sel, inv, 1'b0);
    chk("trigger count", 32'(e), 32'(trig[c] - t0));
    chk("irq count", (sup && idleMode) ? 0 : 32'(e), 32'(irq[c] - i0));
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    chk("status", (32'(e) << (8 + c)) | (32'(inv) << c) | (32'(sup) << 15),
        rd & ((32'h0000_0101 << c) | 32'h0000_8000));
    bus(1'b1, off, 32'h0000_0000);
  endtask
  // bounds a hang; the full run needs about 560 cycles
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    reportAndStop();
  end
  initial begin
    seed = 78927;
    rst_n = 1'b0;
    hSel = 1'b0;
    hAddr = 32'h0000_0000;
    hTrans = 2'b00;
    hWrite = 1'b0;
    hSize = 3'b010;
    hwdata = 32'h0000_0000;
    idleMode = 1'b0;
    posMv = '0;
    negMv = {2{12'd1000}};
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("hreadyout", 32'h0000_0001, 32'(hreadyout));
    chk("hresp", 32'h0000_0000, 32'(hresp));
    // reset values, then one unmapped offset
    for (k = 0; k < 5; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0000_0000);
      chk("reset read", 32'h0000_0000, rd);
    end
    // random setups with the core off, so no event can fire
    repeat (20) begin
      w = $random(seed);
      k = $random(seed) & 1;
      w[EN_BIT] = 1'b0;
      w[EVT_BIT] = 1'b0;
      bus(1'b1, k ? OFF_CTRL2 : OFF_CTRL1, w);
      bus(1'b0, k ? OFF_CTRL2 : OFF_CTRL1, 32'h0000_0000);
      chk("ctrl read", w & 32'(CTRL_WMASK), rd);
      chk("core setup", {27'h0, 1'b0, w[LP_BIT], w[NONINV_BIT], w[1:0]},
          32'(cmpAnalog[k]));
      chk("pin gated", 32'h0000_0000, 32'(cmpPinDrive[k]));
      bus(1'b1, OFF_LADDER, w);
      bus(1'b0, OFF_LADDER, 32'h0000_0000);
      chk("ladder read", w & 32'(LADDER_WMASK), rd);
      chk("ladder setup", {24'h00_0000, w[7:0]}, 32'(ladderAnalog));
    end
    // every edge select with and without inversion on both comparators
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        for (int v = 0; v < 2; v++) begin
          eventCase(c, 2'(s), v[0]);
        end
      end
    end
    reportAndStop();
  end
endmodule // comparator_event_and_vref_control_test
